// ---- design/gpio_port_registers.sv ----
// register file and avalon slave for five gpio ports with pin banks
//
// Summary of operation
// - per-port slew select, reduced rate by default
// - pin-value write updates output latch
// - pin-value read returns sampled pin levels
// - port e bit3 input-only, gated by clear enable
// - analog select one disables digital input buffer
// - port a analog bits 5,3..0 implemented
// - port b analog bits 5..0 implemented
// - port c analog bits 7..2 implemented
// - port d analog all eight bits implemented
// - port e analog bits 2..0 implemented only
// - direction one tri-states, zero drives, reset one
// - port e direction bits 2..0, bit 7 pin3 pull-up, others zero
// - latches read/write, unknown at power-on, kept
// - port e latch bits 2..0 only
// - pin-value bits unknown at power-on
// - analog-selected pins read as zero
// - analog select leaves digital output untouched
//
// Decided for this implementation: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ns
module gpio_port_registers
    import gpio_pkg::*;
(
    input  wire logic              i_clock,
    input  wire logic              i_nrst,
    input  wire logic              i_other_reset,
    input  wire logic [ADDR_W-1:0] i_avs_address,
    input  wire logic              i_avs_read,
    input  wire logic              i_avs_write,
    input  wire logic [DATA_W-1:0] i_avs_writedata,
    input  wire logic [3:0]        i_avs_byteenable,
    output logic      [DATA_W-1:0] o_avs_readdata,
    output logic                   o_avs_waitrequest,
    input  wire logic [PORT_W-1:0] i_pin_a,
    input  wire logic [PORT_W-1:0] i_pin_b,
    input  wire logic [PORT_W-1:0] i_pin_c,
    input  wire logic [PORT_W-1:0] i_pin_d,
    input  wire logic [2:0]        i_pin_e,
    input  wire logic              i_port_e_pin3,
    output logic      [PORT_W-1:0] o_pin_a_out,
    output logic      [PORT_W-1:0] o_pin_b_out,
    output logic      [PORT_W-1:0] o_pin_c_out,
    output logic      [PORT_W-1:0] o_pin_d_out,
    output logic      [2:0]        o_pin_e_out,
    output logic      [PORT_W-1:0] o_pin_a_oe_n,
    output logic      [PORT_W-1:0] o_pin_b_oe_n,
    output logic      [PORT_W-1:0] o_pin_c_oe_n,
    output logic      [PORT_W-1:0] o_pin_d_oe_n,
    output logic      [2:0]        o_pin_e_oe_n,
    output logic      [PORT_W-1:0] o_pullup_b,
    output logic                   o_pullup_e3,
    output logic      [SLEW_W-1:0] o_slew_reduced
);

    // map a word index onto its register group
    function automatic access_group_t access_group(input logic [IDX_W-1:0] idx);
        access_group_t grp;
        grp = GRP_NONE;
        if (idx < IDX_LATCH_BASE)
            grp = GRP_PIN;
        else if (idx < IDX_DIR_BASE)
            grp = GRP_LATCH;
        else if (idx < IDX_ANA_BASE)
            grp = GRP_DIR;
        else if (idx < IDX_PULLUP_B)
            grp = GRP_ANA;
        else if (idx == IDX_PULLUP_B)
            grp = GRP_PULLUP;
        else if (idx == IDX_SLEW)
            grp = GRP_SLEW;
        else if (idx == IDX_CONFIG)
            grp = GRP_CONFIG;
        return grp;
    endfunction : access_group

    // port number within a per-port group
    function automatic logic [2:0] port_of(input logic [IDX_W-1:0] idx);
        logic [IDX_W-1:0] off;
        off = idx - IDX_PIN_BASE;
        if (idx >= IDX_ANA_BASE)
            off = idx - IDX_ANA_BASE;
        else if (idx >= IDX_DIR_BASE)
            off = idx - IDX_DIR_BASE;
        else if (idx >= IDX_LATCH_BASE)
            off = idx - IDX_LATCH_BASE;
        return off[2:0];
    endfunction : port_of

    acc_state_t        state_reg;
    acc_state_t        state_next;
    logic [PORT_W-1:0] latch_reg  [NUM_PORTS];
    logic [PORT_W-1:0] dir_reg    [NUM_PORTS];
    logic [PORT_W-1:0] ana_reg    [NUM_PORTS];
    logic [PORT_W-1:0] pins_in    [NUM_PORTS];
    logic [PORT_W-1:0] pin_sample [NUM_PORTS];
    logic [PORT_W-1:0] pin_out    [NUM_PORTS];
    logic [PORT_W-1:0] pin_oe_n   [NUM_PORTS];
    logic [PORT_W-1:0] pullup_b_reg;
    logic [SLEW_W-1:0] slew_reg;
    logic              mclr_en_reg;
    logic [DATA_W-1:0] readdata_reg;
    logic [DATA_W-1:0] readdata_next;

    logic [IDX_W-1:0]  idx;
    access_group_t     grp;
    logic [2:0]        port_sel;
    logic              request;
    logic              wr_ack;
    logic              wr_lane0;
    logic [PORT_W-1:0] wdata;
    logic [PORT_W-1:0] rd_byte;
    logic [PORT_W-1:0] sample_sel;

    // address decode
    assign idx      = i_avs_address[ADDR_W-1:2];
    assign grp      = access_group(idx);
    assign port_sel = port_of(idx);
    assign request  = i_avs_read | i_avs_write;
    assign wdata    = i_avs_writedata[PORT_W-1:0];

    // one wait cycle per access: the answer edge is the second edge
    assign o_avs_waitrequest = request & (state_reg == ACC_IDLE);
    assign wr_ack   = i_avs_write & (state_reg == ACC_ANSWER);
    assign wr_lane0 = wr_ack & i_avs_byteenable[0];

    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            ACC_IDLE:   state_next = request ? ACC_ANSWER : ACC_IDLE;
            ACC_ANSWER: state_next = ACC_IDLE;
            default:    state_next = ACC_IDLE;
        endcase
    end

    always_ff @(posedge i_clock or negedge i_nrst)
    begin
        if (!i_nrst)
            state_reg <= ACC_IDLE;
        else
            state_reg <= state_next;
    end

    // port e pin3 reads as an input only while the clear function is off
    assign pins_in[0] = i_pin_a;
    assign pins_in[1] = i_pin_b;
    assign pins_in[2] = i_pin_c;
    assign pins_in[3] = i_pin_d;
    assign pins_in[4] = {4'h0, i_port_e_pin3 & ~mclr_en_reg, i_pin_e};

    // per-port control registers and pin banks
    genvar p;
    generate
        for (p = 0; p < NUM_PORTS; p++)
        begin : g_port
            logic hit;
            assign hit = wr_lane0 && (port_sel == 3'(p));

            // latch has no reset: unknown at power-on, kept over other resets
            always_ff @(posedge i_clock)
            begin
                if (hit && (grp == GRP_PIN || grp == GRP_LATCH))
                    latch_reg[p] <= wdata & LATCH_MASK[p];
            end

            // direction and analog select come up with every implemented bit set on either reset
            always_ff @(posedge i_clock or negedge i_nrst)
            begin
                if (!i_nrst)
                begin
                    dir_reg[p] <= DIR_MASK[p];
                    ana_reg[p] <= ANA_MASK[p];
                end
                else if (i_other_reset)
                begin
                    dir_reg[p] <= DIR_MASK[p];
                    ana_reg[p] <= ANA_MASK[p];
                end
                else
                begin
                    if (hit && grp == GRP_DIR)
                        dir_reg[p] <= wdata & DIR_MASK[p];
                    if (hit && grp == GRP_ANA)
                        ana_reg[p] <= wdata & ANA_MASK[p];
                end
            end

            gpio_pin_bank u_bank (
                .i_clock    (i_clock),
                .i_pins     (pins_in[p]),
                .i_latch    (latch_reg[p]),
                .i_dir      (dir_reg[p]),
                .i_analog   (ana_reg[p]),
                .i_mask     (PIN_MASK[p]),
                .o_sample   (pin_sample[p]),
                .o_pin_out  (pin_out[p]),
                .o_pin_oe_n (pin_oe_n[p])
            );
        end
    endgenerate

    // shared controls: pull-ups, slew and the clear-enable configuration
    always_ff @(posedge i_clock or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            pullup_b_reg <= PULLUP_B_RESET;
            slew_reg     <= SLEW_RESET;
            mclr_en_reg  <= MCLR_RESET;
        end
        else if (i_other_reset)
        begin
            pullup_b_reg <= PULLUP_B_RESET;
            slew_reg     <= SLEW_RESET;
        end
        else
        begin
            if (wr_lane0 && grp == GRP_PULLUP)
                pullup_b_reg <= wdata;
            if (wr_lane0 && grp == GRP_SLEW)
                slew_reg <= wdata[SLEW_W-1:0];
            if (wr_lane0 && grp == GRP_CONFIG)
                mclr_en_reg <= wdata[MCLR_BIT];
        end
    end

    // read selection; pin group returns sampled pins, never the latch
    assign sample_sel = pin_sample[port_sel];
    assign rd_byte =
        (grp == GRP_PIN)    ? sample_sel :
        (grp == GRP_LATCH)  ? latch_reg[port_sel] & LATCH_MASK[port_sel] :
        (grp == GRP_DIR)    ? dir_reg[port_sel] :
        (grp == GRP_ANA)    ? ana_reg[port_sel] :
        (grp == GRP_PULLUP) ? pullup_b_reg :
        (grp == GRP_SLEW)   ? {3'h0, slew_reg} :
        (grp == GRP_CONFIG) ? {7'h00, mclr_en_reg} :
                              8'h00; // unmapped reads zero
    assign readdata_next = {24'h000000, rd_byte};

    // data is captured on the waiting edge so it stands at the answer edge
    always_ff @(posedge i_clock or negedge i_nrst)
    begin
        if (!i_nrst)
            readdata_reg <= 32'h00000000;
        else if (i_avs_read && state_reg == ACC_IDLE)
            readdata_reg <= readdata_next;
    end
    assign o_avs_readdata = readdata_reg;

    // pin-facing outputs
    assign o_pin_a_out    = pin_out[0];
    assign o_pin_b_out    = pin_out[1];
    assign o_pin_c_out    = pin_out[2];
    assign o_pin_d_out    = pin_out[3];
    assign o_pin_e_out    = pin_out[4][2:0];
    assign o_pin_a_oe_n   = pin_oe_n[0];
    assign o_pin_b_oe_n   = pin_oe_n[1];
    assign o_pin_c_oe_n   = pin_oe_n[2];
    assign o_pin_d_oe_n   = pin_oe_n[3];
    assign o_pin_e_oe_n   = pin_oe_n[4][2:0];
    assign o_pullup_b     = pullup_b_reg;
    assign o_pullup_e3    = dir_reg[4][PULLUP_E3_BIT];
    assign o_slew_reduced = slew_reg;

    // checks
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_nrst);

    sequence s_request;
        request && o_avs_waitrequest;
    endsequence
    sequence s_answer;
        !o_avs_waitrequest && state_reg == ACC_ANSWER;
    endsequence

    property p_answer_one_wait;
        s_request |=> s_answer;
    endproperty
    a_answer_one_wait: assert property (p_answer_one_wait)
        else $error("access not answered after one wait cycle");

    property p_pin_write_latch;
        (wr_lane0 && grp == GRP_PIN && port_sel == PORT_A)
            |=> latch_reg[0] == $past(wdata);
    endproperty
    a_pin_write_latch: assert property (p_pin_write_latch)
        else $error("pin-value write did not reach the latch");

    property p_read_pins;
        (i_avs_read && state_reg == ACC_ANSWER && grp == GRP_PIN)
            |-> o_avs_readdata[PORT_W-1:0] == $past(sample_sel);
    endproperty
    a_read_pins: assert property (p_read_pins)
        else $error("pin-value read did not return sampled pins");

    property p_analog_gate;
        ana_reg[3][0] && !i_other_reset |=> !pin_sample[3][0];
    endproperty
    a_analog_gate: assert property (p_analog_gate)
        else $error("analog-selected pin read nonzero");

    property p_drive_analog;
        !dir_reg[3][5] && ana_reg[3][5] |-> o_pin_d_out[5] == latch_reg[3][5] && !o_pin_d_oe_n[5];
    endproperty
    a_drive_analog: assert property (p_drive_analog)
        else $error("analog select disturbed output drive");

    property p_high_zero;
        s_answer |-> o_avs_readdata[DATA_W-1:PORT_W] == 24'h000000;
    endproperty
    a_high_zero: assert property (p_high_zero)
        else $error("upper read bits nonzero");

    property p_ana_a_unimpl;
        (i_avs_read && state_reg == ACC_ANSWER && grp == GRP_ANA && port_sel == PORT_A)
            |-> o_avs_readdata[7:6] == 2'h0 && !o_avs_readdata[4];
    endproperty
    a_ana_a_unimpl: assert property (p_ana_a_unimpl)
        else $error("port a analog unimplemented bits nonzero");

    property p_e3_gated;
        mclr_en_reg && $stable(mclr_en_reg) |-> !pin_sample[4][E3_BIT];
    endproperty
    a_e3_gated: assert property (p_e3_gated)
        else $error("port e pin3 read while clear function enabled");

    property p_slew_reset;
        i_other_reset |=> o_slew_reduced == SLEW_RESET && dir_reg[0] == DIR_MASK[0];
    endproperty
    a_slew_reset: assert property (p_slew_reset)
        else $error("slew or direction not restored by reset");

    property p_pullup_e3;
        (wr_lane0 && grp == GRP_DIR && port_sel == PORT_E && !i_other_reset)
            |=> o_pullup_e3 == $past(wdata[PULLUP_E3_BIT])
                && (dir_reg[4] & ~DIR_E_LO_MASK) == {$past(wdata[PULLUP_E3_BIT]), 7'h00};
    endproperty
    a_pullup_e3: assert property (p_pullup_e3)
        else $error("port e pull-up bit not taken from direction write");

    property p_latch_e;
        (wr_lane0 && grp == GRP_LATCH && port_sel == PORT_E) |=> latch_reg[4][7:3] == 5'h00;
    endproperty
    a_latch_e: assert property (p_latch_e)
        else $error("port e latch upper bits stored");

endmodule : gpio_port_registers

// ---- design/gpio_pkg.sv ----
// shared constants, register map and types for the five-port gpio block
package gpio_pkg;

    localparam int NUM_PORTS = 5;
    localparam int PORT_W    = 8;
    localparam int ADDR_W    = 8;
    localparam int DATA_W    = 32;
    localparam int IDX_W     = 6;
    localparam int SLEW_W    = 5;

    // word index of each register; byte address is index times four
    localparam logic [IDX_W-1:0] IDX_PIN_BASE   = 6'h00;
    localparam logic [IDX_W-1:0] IDX_LATCH_BASE = 6'h05;
    localparam logic [IDX_W-1:0] IDX_DIR_BASE   = 6'h0A;
    localparam logic [IDX_W-1:0] IDX_ANA_BASE   = 6'h0F;
    localparam logic [IDX_W-1:0] IDX_PULLUP_B   = 6'h14;
    localparam logic [IDX_W-1:0] IDX_SLEW       = 6'h15;
    localparam logic [IDX_W-1:0] IDX_CONFIG     = 6'h16;

    // implemented bits per port, index 0 is port a and 4 is port e
    localparam logic [PORT_W-1:0] ANA_MASK   [NUM_PORTS] = '{8'h2F, 8'h3F, 8'hFC, 8'hFF, 8'h07};
    localparam logic [PORT_W-1:0] DIR_MASK   [NUM_PORTS] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h87};
    localparam logic [PORT_W-1:0] LATCH_MASK [NUM_PORTS] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h07};
    localparam logic [PORT_W-1:0] PIN_MASK   [NUM_PORTS] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h0F};

    localparam logic [2:0]        PORT_A         = 3'h0;
    localparam logic [2:0]        PORT_E         = 3'h4;
    localparam int                E3_BIT         = 3;
    localparam int                PULLUP_E3_BIT  = 7;
    localparam int                MCLR_BIT       = 0;
    localparam logic [PORT_W-1:0] PULLUP_B_RESET = 8'hFF;
    localparam logic [SLEW_W-1:0] SLEW_RESET     = 5'h1F;
    localparam logic              MCLR_RESET     = 1'b1;
    localparam logic [PORT_W-1:0] DIR_E_LO_MASK  = 8'h07;

    typedef enum logic [2:0] {
        GRP_PIN,
        GRP_LATCH,
        GRP_DIR,
        GRP_ANA,
        GRP_PULLUP,
        GRP_SLEW,
        GRP_CONFIG,
        GRP_NONE
    } access_group_t;

    typedef enum logic {
        ACC_IDLE,
        ACC_ANSWER
    } acc_state_t;

endpackage : gpio_pkg

// ---- design/gpio_pin_bank.sv ----
// one port's pin logic: input buffer gating, sampling and output drive
`timescale 1ns/1ns
module gpio_pin_bank
    import gpio_pkg::*;
(
    input  wire logic              i_clock,
    input  wire logic [PORT_W-1:0] i_pins,
    input  wire logic [PORT_W-1:0] i_latch,
    input  wire logic [PORT_W-1:0] i_dir,
    input  wire logic [PORT_W-1:0] i_analog,
    input  wire logic [PORT_W-1:0] i_mask,
    output logic      [PORT_W-1:0] o_sample,
    output logic      [PORT_W-1:0] o_pin_out,
    output logic      [PORT_W-1:0] o_pin_oe_n
);

    logic [PORT_W-1:0] gated_in;

    // analog pins read zero; unimplemented pins read zero
    assign gated_in = i_pins & ~i_analog & i_mask;

    // analog select does not touch the output path; tri-stated pins drive 0
    assign o_pin_out  = i_latch & ~i_dir & i_mask;
    assign o_pin_oe_n = i_dir | ~i_mask;

    // no reset: pin levels are unknown until the first sample after power-on
    always_ff @(posedge i_clock)
    begin
        o_sample <= gated_in;
    end

endmodule : gpio_pin_bank

// ---- verification/gpio_pad_model.sv ----
// board-side pad model: resolves each pin from the gpio drive and the board source
`timescale 1ns/1ns
module gpio_pad_model
#(
    parameter int W = 8
)
(
    input  wire logic [W-1:0] i_out,
    input  wire logic [W-1:0] i_oe_n,
    input  wire logic [W-1:0] i_ext,
    output logic      [W-1:0] o_level
);
    // the gpio wins where it drives; the board source only shows on released pins
    assign o_level = (i_out & ~i_oe_n) | (i_ext & i_oe_n);
endmodule : gpio_pad_model

// ---- verification/gpio_port_registers_tb.sv ----
// self-checking bench for the five-port gpio register block
`timescale 1ns/1ns
module gpio_port_registers_tb
    import gpio_pkg::*;
;
    logic              clock;
    logic              nrst;
    logic              other_rst;
    logic [ADDR_W-1:0] address;
    logic              rd;
    logic              wr;
    logic [DATA_W-1:0] wdata;
    logic [3:0]        be;
    logic [DATA_W-1:0] rdata;
    logic              waitreq;
    logic [7:0]        ext_a, ext_b, ext_c, ext_d, pull_b;
    logic [7:0]        lvl_a, lvl_b, lvl_c, lvl_d, out_a, out_b, out_c, out_d;
    logic [7:0]        oen_a, oen_b, oen_c, oen_d;
    logic [2:0]        ext_e, lvl_e, out_e, oen_e;
    logic              pin_e3;
    logic              pull_e3;
    logic [4:0]        slew;
    logic [7:0]        got;
    logic [7:0]        v;
    int                err_count;
    int                samples_checked;
    // implemented-bit masks, one entry per port a..e
    localparam logic [7:0] ANA_EXP [5] = '{8'h2F, 8'h3F, 8'hFC, 8'hFF, 8'h07};
    localparam logic [7:0] DIR_EXP [5] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h87};
    localparam logic [7:0] LAT_EXP [5] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h07};

    gpio_port_registers u_dut (
        .i_clock(clock), .i_nrst(nrst), .i_other_reset(other_rst),
        .i_avs_address(address), .i_avs_read(rd), .i_avs_write(wr),
        .i_avs_writedata(wdata), .i_avs_byteenable(be),
        .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq),
        .i_pin_a(lvl_a), .i_pin_b(lvl_b), .i_pin_c(lvl_c), .i_pin_d(lvl_d),
        .i_pin_e(lvl_e), .i_port_e_pin3(pin_e3),
        .o_pin_a_out(out_a), .o_pin_b_out(out_b), .o_pin_c_out(out_c),
        .o_pin_d_out(out_d), .o_pin_e_out(out_e),
        .o_pin_a_oe_n(oen_a), .o_pin_b_oe_n(oen_b), .o_pin_c_oe_n(oen_c),
        .o_pin_d_oe_n(oen_d), .o_pin_e_oe_n(oen_e),
        .o_pullup_b(pull_b), .o_pullup_e3(pull_e3), .o_slew_reduced(slew)
    );

    // one pad model per port so reads see what the pins really carry
    gpio_pad_model #(.W(8)) u_pad_a
        (.i_out(out_a), .i_oe_n(oen_a), .i_ext(ext_a), .o_level(lvl_a));
    gpio_pad_model #(.W(8)) u_pad_b
        (.i_out(out_b), .i_oe_n(oen_b), .i_ext(ext_b), .o_level(lvl_b));
    gpio_pad_model #(.W(8)) u_pad_c
        (.i_out(out_c), .i_oe_n(oen_c), .i_ext(ext_c), .o_level(lvl_c));
    gpio_pad_model #(.W(8)) u_pad_d
        (.i_out(out_d), .i_oe_n(oen_d), .i_ext(ext_d), .o_level(lvl_d));
    gpio_pad_model #(.W(3)) u_pad_e
        (.i_out(out_e), .i_oe_n(oen_e), .i_ext(ext_e), .o_level(lvl_e));

    // 125 MHz clock
    initial
    begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] seen);
        samples_checked++;
        if (seen !== exp)
        begin
            err_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // one avalon transfer; request held until the edge that sees waitrequest low
    task automatic bus_cycle(input logic [5:0] idx, input logic is_wr, input logic [7:0] d,
                             input logic [3:0] lanes);
        int n;
        n = 0;
        @(posedge clock);
        address <= {idx, 2'b00};
        rd      <= ~is_wr;
        wr      <= is_wr;
        wdata   <= {24'h000000, d};
        be      <= lanes;
        do
        begin
            @(negedge clock);
            n++;
        end
        while (waitreq !== 1'b0 && n < 100);
        if (waitreq !== 1'b0)
            err_count++; // slave never answered
        @(posedge clock);
        got = rdata[7:0];
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus_cycle

    task automatic write_reg(input logic [5:0] idx, input logic [7:0] d);
        bus_cycle(idx, 1'b1, d, 4'h1);
        // the write lands on the edge just passed; wait one more so outputs have settled
        @(posedge clock);
    endtask : write_reg

    task automatic read_check(input string name, input logic [5:0] idx, input logic [7:0] exp);
        bus_cycle(idx, 1'b0, 8'h00, 4'h1);
        check(name, exp, got);
    endtask : read_check

    task automatic complete_run();
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : complete_run

    // whole sequence needs a few hundred cycles; this bound only catches a hang
    initial
    begin
        #200000;
        err_count++;
        complete_run();
    end

    initial
    begin
        nrst = 1'b0;
        other_rst = 1'b0;
        address = '0;
        rd = 1'b0;
        wr = 1'b0;
        wdata = '0;
        be = 4'h1;
        {ext_a, ext_b, ext_c, ext_d, ext_e} = '0;
        pin_e3 = 1'b1;
        err_count = 0;
        samples_checked = 0;
        repeat (16) @(posedge clock);
        nrst <= 1'b1;
        check("oe_n a", 8'hFF, oen_a);
        check("pullup b", 8'hFF, pull_b);
        check("pullup e3", 8'h01, {7'h00, pull_e3});
        check("slew", 8'h1F, {3'h0, slew});
        for (int p = 0; p < 5; p++)
        begin
            read_check("ana rst", IDX_ANA_BASE + 6'(p), ANA_EXP[p]);
            read_check("dir rst", IDX_DIR_BASE + 6'(p), DIR_EXP[p]);
        end
        read_check("pullup rst", IDX_PULLUP_B, 8'hFF);
        read_check("slew rst", IDX_SLEW, 8'h1F);
        // ones then zeros into every analog, direction and latch register; unimplemented bits must stay clear
        for (int k = 0; k < 2; k++)
        begin
            v = (k == 0) ? 8'hFF : 8'h00;
            for (int p = 0; p < 5; p++)
            begin
                write_reg(IDX_ANA_BASE + 6'(p), v);
                read_check("ana rw", IDX_ANA_BASE + 6'(p), v & ANA_EXP[p]);
                write_reg(IDX_DIR_BASE + 6'(p), v);
                read_check("dir rw", IDX_DIR_BASE + 6'(p), v & DIR_EXP[p]);
                write_reg(IDX_LATCH_BASE + 6'(p), v);
                read_check("lat rw", IDX_LATCH_BASE + 6'(p), v & LAT_EXP[p]);
            end
        end
        check("pullup e3 off", 8'h00, {7'h00, pull_e3});
        check("oe_n bcd", 8'h00, oen_b | oen_c | oen_d);
        check("oe_n e", 8'h00, {5'h00, oen_e});
        check("drive bc", 8'h00, out_b | out_c);
        // analog select on a driven port d pin leaves the drive alone
        write_reg(IDX_PIN_BASE + 6'h03, 8'h66);
        write_reg(IDX_ANA_BASE + 6'h03, 8'hFF);
        check("drive d ana", 8'h66, out_d);
        read_check("pin d ana", IDX_PIN_BASE + 6'h03, 8'h00);
        // pin-value write lands in the latch and drives the outputs
        write_reg(IDX_PIN_BASE, 8'hA5);
        read_check("lat a", IDX_LATCH_BASE, 8'hA5);
        check("drive a", 8'hA5, out_a);
        check("oe_n a drv", 8'h00, oen_a);
        write_reg(IDX_ANA_BASE, 8'hFF);
        check("drive a ana", 8'hA5, out_a);
        read_check("pin a ana", IDX_PIN_BASE, 8'h80);
        write_reg(IDX_ANA_BASE, 8'h00);
        write_reg(IDX_DIR_BASE, 8'hFF);
        ext_a <= 8'h3C;
        read_check("pin a in", IDX_PIN_BASE, 8'h3C);
        read_check("lat a kept", IDX_LATCH_BASE, 8'hA5);
        // port e: pin3 only readable once the clear function is off
        write_reg(IDX_DIR_BASE + 6'h04, 8'h07);
        ext_e <= 3'h5;
        read_check("pin e mclr", IDX_PIN_BASE + 6'h04, 8'h05);
        write_reg(IDX_CONFIG, 8'h00);
        read_check("pin e", IDX_PIN_BASE + 6'h04, 8'h0D);
        write_reg(IDX_DIR_BASE + 6'h04, 8'h80);
        write_reg(IDX_PIN_BASE + 6'h04, 8'hFF);
        check("pullup e3 on", 8'h01, {7'h00, pull_e3});
        check("drive e", 8'h07, {5'h00, out_e});
        read_check("pin e drv", IDX_PIN_BASE + 6'h04, 8'h0F);
        // slew, pull-ups, refused writes
        write_reg(IDX_SLEW, 8'hEA);
        check("slew out", 8'h0A, {3'h0, slew});
        read_check("slew rd", IDX_SLEW, 8'h0A);
        bus_cycle(IDX_SLEW, 1'b1, 8'h15, 4'h0);
        read_check("slew no lane", IDX_SLEW, 8'h0A);
        write_reg(6'h20, 8'hFF);
        read_check("unmapped", 6'h20, 8'h00);
        write_reg(IDX_PULLUP_B, 8'h5A);
        check("pullup b wr", 8'h5A, pull_b);
        // other reset: controls reload, latch and config survive
        @(posedge clock);
        other_rst <= 1'b1;
        @(posedge clock);
        other_rst <= 1'b0;
        read_check("lat a other", IDX_LATCH_BASE, 8'hA5);
        read_check("ana a other", IDX_ANA_BASE, 8'h2F);
        read_check("pin e other", IDX_PIN_BASE + 6'h04, 8'h08);
        check("slew other", 8'h1F, {3'h0, slew});
        check("pullup b other", 8'hFF, pull_b);
        complete_run();
    end
endmodule : gpio_port_registers_tb
